// ### hw/multiplexed_switch_reader.sv
`include "switch_reader_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module multiplexed_switch_reader #(
  parameter int unsigned SCAN_CYCLES = `SCAN_CYCLES
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire switch_reader_pkg::apb_req_t   apb_req_i,
  output var  switch_reader_pkg::apb_rsp_t   apb_rsp_o,
  input  wire logic [7:0]                    switch_input_base_i,
  output var  logic [3:0]                    strobe_output_base_o,
  output var  logic                          read_complete_flag_o,
  output var  logic                          operation_error_flag_o,
  output var  logic [15:0]                   error_code_word_o,
  output var  logic                          irq_o
);
  import switch_reader_pkg::*;

  localparam int unsigned BANKS = 2;

  function automatic logic [15:0] bcd_to_bin(input logic [15:0] d);
    bcd_to_bin = ({12'h000, d[15:12]} * 16'h03E8) + ({12'h000, d[11:8]} * 16'h0064)
               + ({12'h000, d[7:4]} * 16'h000A) + {12'h000, d[3:0]};
  endfunction : bcd_to_bin

  // scan group state
  scan_state_t  state;
  scan_state_t  next_state;
  logic [1:0]   step;
  logic [1:0]   next_step;
  logic [15:0]  div;
  logic [15:0]  next_div;
  logic [15:0]  digits      [BANKS];
  logic [15:0]  next_digits [BANKS];
  logic [15:0]  merged      [BANKS];
  logic [15:0]  conv        [BANKS];
  logic [15:0]  value       [BANKS];
  logic [15:0]  next_value  [BANKS];
  logic [3:0]   next_strobe;
  logic         next_complete;
  logic [15:0]  next_errcode;
  logic         done_event;
  logic         fault_event;
  logic         tick;

  // bus group state
  logic         ctrl_enable;
  logic         next_ctrl_enable;
  logic [15:0]  count_sel;
  logic [15:0]  next_count_sel;
  logic [1:0]   status;
  logic [1:0]   next_status;
  logic [1:0]   mask;
  logic [1:0]   next_mask;
  logic         next_irq;
  apb_rsp_t     next_rsp;
  logic         sel_valid;
  logic         access;
  logic         wr_take;
  logic         mapped;
  logic [31:0]  rd_data;

  assign tick      = (div == 16'(SCAN_CYCLES - 1));
  assign sel_valid = (count_sel == `SEL_ONE) || (count_sel == `SEL_TWO);

  // per-bank digit capture and conversion
  for (genvar b = 0; b < BANKS; b++)
  begin : g_bank
    always_comb
    begin
      merged[b] = digits[b];
      merged[b][{step, 2'b00} +: 4] = switch_input_base_i[b*4 +: 4];
    end
    assign conv[b] = bcd_to_bin(merged[b]);
  end

  always_comb
  begin
    next_state    = state;
    next_step     = step;
    next_div      = div;
    next_digits   = digits;
    next_value    = value;
    next_complete = read_complete_flag_o;
    next_errcode  = error_code_word_o;
    done_event    = 1'b0;
    fault_event   = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        // disabled: sequence restarts from the first strobe
        next_div  = 16'h0000;
        next_step = 2'h0;
        if (ctrl_enable && sel_valid)
        begin
          next_state = ST_SCAN;
        end
        else if (ctrl_enable)
        begin
          next_state   = ST_FAULT;
          fault_event  = 1'b1;
          next_errcode = `ERR_RANGE;
        end
      end
      ST_SCAN:
      begin
        if (!ctrl_enable)
        begin
          next_state    = ST_IDLE;
          next_complete = 1'b0;
        end
        else if (!sel_valid)
        begin
          next_state    = ST_FAULT;
          fault_event   = 1'b1;
          next_errcode  = `ERR_RANGE;
          next_complete = 1'b0;
        end
        else if (tick)
        begin
          next_div      = 16'h0000;
          next_complete = 1'b0;
          next_digits   = merged;
          next_step     = 2'(step + 2'h1);
          if (step == 2'h3)
          begin
            next_value[0] = conv[0];
            if (count_sel == `SEL_TWO)
            begin
              next_value[1] = conv[1];
            end
            next_complete = 1'b1;
            done_event    = 1'b1;
          end
        end
        else
        begin
          next_div = 16'(div + 16'h0001);
        end
      end
      ST_FAULT:
      begin
        if (!ctrl_enable)
        begin
          next_state = ST_IDLE;
        end
      end
    endcase
    next_strobe = (next_state == ST_SCAN) ? 4'(4'h1 << next_step) : 4'h0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state                <= ST_IDLE;
      step                 <= 2'h0;
      div                  <= 16'h0000;
      digits[0]            <= 16'h0000;
      digits[1]            <= 16'h0000;
      value[0]             <= 16'h0000;
      value[1]             <= 16'h0000;
      strobe_output_base_o <= 4'h0;
      read_complete_flag_o <= 1'b0;
      error_code_word_o    <= `RST_ERRCODE;
    end
    else
    begin
      state                <= next_state;
      step                 <= next_step;
      div                  <= next_div;
      digits               <= next_digits;
      value                <= next_value;
      strobe_output_base_o <= next_strobe;
      read_complete_flag_o <= next_complete;
      error_code_word_o    <= next_errcode;
    end
  end

  // apb slave: one wait state, answer registered
  assign access  = apb_req_i.psel && apb_req_i.penable;
  assign wr_take = access && apb_req_i.pwrite && apb_rsp_o.pready;

  always_comb
  begin
    mapped  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (apb_req_i.paddr)
      `OFF_CTRL:    rd_data = {31'h0000_0000, ctrl_enable};
      `OFF_SEL:     rd_data = {16'h0000, count_sel};
      `OFF_STATUS:  rd_data = {30'h0000_0000, status};
      `OFF_MASK:    rd_data = {30'h0000_0000, mask};
      `OFF_VALUE0:  rd_data = {16'h0000, value[0]};
      `OFF_VALUE1:  rd_data = {16'h0000, value[1]};
      `OFF_ERRCODE: rd_data = {16'h0000, error_code_word_o};
      `OFF_WORK0:   rd_data = {13'h0, state, div};
      `OFF_WORK1:   rd_data = {digits[1], digits[0]};
      default:      mapped  = 1'b0;
    endcase
  end

  always_comb
  begin
    next_ctrl_enable = ctrl_enable;
    next_count_sel   = count_sel;
    next_mask        = mask;
    next_status      = status;
    next_rsp         = apb_rsp_o;
    next_rsp.pready  = access && !apb_rsp_o.pready;
    if (access && !apb_rsp_o.pready)
    begin
      next_rsp.prdata  = apb_req_i.pwrite ? 32'h0000_0000 : rd_data;
      next_rsp.pslverr = !mapped;
    end
    else if (!access)
    begin
      next_rsp.pslverr = 1'b0;
    end
    // value, code and work words ignore writes
    if (wr_take)
    begin
      unique case (apb_req_i.paddr)
        `OFF_CTRL:   next_ctrl_enable = apb_req_i.pwdata[`BIT_ENABLE];
        `OFF_SEL:    next_count_sel   = apb_req_i.pwdata[15:0];
        `OFF_STATUS: next_status      = status & ~apb_req_i.pwdata[1:0];
        `OFF_MASK:   next_mask        = apb_req_i.pwdata[1:0];
        default:     next_status      = status;
      endcase
    end
    // hardware set wins over a same-cycle clear
    next_status[`BIT_DONE]  = next_status[`BIT_DONE] | done_event;
    next_status[`BIT_ERROR] = next_status[`BIT_ERROR] | fault_event;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_enable            <= `RST_ENABLE;
      count_sel              <= `RST_SEL;
      status                 <= 2'h0;
      mask                   <= `RST_MASK;
      apb_rsp_o              <= '0;
      irq_o                  <= 1'b0;
      operation_error_flag_o <= 1'b0;
    end
    else
    begin
      ctrl_enable            <= next_ctrl_enable;
      count_sel              <= next_count_sel;
      status                 <= next_status;
      mask                   <= next_mask;
      apb_rsp_o              <= next_rsp;
      irq_o                  <= next_irq;
      operation_error_flag_o <= next_status[`BIT_ERROR];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_strobe_off_disabled: assert property (!ctrl_enable |=> strobe_output_base_o == 4'h0)
    else $error("strobe active while disabled");
  a_strobe_one_hot: assert property (state == ST_SCAN |-> $onehot(strobe_output_base_o))
    else $error("strobe not one-hot in scan");
  a_strobe_rotates: assert property (state == ST_SCAN && ctrl_enable && sel_valid && tick
    |=> strobe_output_base_o == {$past(strobe_output_base_o[2:0]), $past(strobe_output_base_o[3])})
    else $error("strobe did not advance");
  a_complete_one_scan: assert property (read_complete_flag_o && tick && state == ST_SCAN
    |=> !read_complete_flag_o)
    else $error("complete flag longer than one scan");
  a_complete_after_last: assert property ($rose(read_complete_flag_o)
    |-> $past(strobe_output_base_o) == 4'h8 && status[`BIT_DONE])
    else $error("complete flag without full read");
  a_value_first_bank: assert property (done_event |=> value[0] == $past(conv[0]))
    else $error("first bank value not stored");
  a_value_one_bank: assert property (done_event && count_sel == `SEL_ONE |=> $stable(value[1]))
    else $error("second word written with one bank");
  a_value_two_bank: assert property (done_event && count_sel == `SEL_TWO
    |=> value[1] == $past(conv[1]))
    else $error("second bank value not stored");
  a_digit_sampled: assert property (state == ST_SCAN && ctrl_enable && sel_valid && tick
    |=> digits[0] == $past(merged[0]) && digits[1] == $past(merged[1]))
    else $error("digits not sampled on step");
  a_fault_reported: assert property (fault_event
    |=> error_code_word_o == `ERR_RANGE && operation_error_flag_o && strobe_output_base_o == 4'h0)
    else $error("range fault not reported");
  a_fault_no_read: assert property (state == ST_FAULT |-> !done_event && $stable(value[0]))
    else $error("read performed during fault");

endmodule : multiplexed_switch_reader

`default_nettype wire

// ### hw/switch_reader_consts.svh
`ifndef SWITCH_READER_CONSTS_SVH
`define SWITCH_READER_CONSTS_SVH

// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_SEL       8'h04
`define OFF_STATUS    8'h08
`define OFF_MASK      8'h0C
`define OFF_VALUE0    8'h10
`define OFF_VALUE1    8'h14
`define OFF_ERRCODE   8'h18
`define OFF_WORK0     8'h1C
`define OFF_WORK1     8'h20

// field positions
`define BIT_ENABLE    0
`define BIT_DONE      0
`define BIT_ERROR     1

// reset values
`define RST_ENABLE    1'b0
`define RST_SEL       16'h0001
`define RST_MASK      2'h0
`define RST_ERRCODE   16'h0000

// bank selector range and error code
`define SEL_ONE       16'h0001
`define SEL_TWO       16'h0002
`define ERR_RANGE     16'h200B

// timing: scan period derived from clock period
`define CLK_PERIOD_NS 5
`define SCAN_TIME_NS  1000
`define SCAN_CYCLES   (`SCAN_TIME_NS / `CLK_PERIOD_NS)

`endif

// ### hw/switch_reader_pkg.sv
package switch_reader_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SCAN  = 3'b010,
    ST_FAULT = 3'b100
  } scan_state_t;

endpackage : switch_reader_pkg

// ### tb/multiplexed_switch_reader_tb.sv
`include "switch_reader_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module multiplexed_switch_reader_tb;
  import switch_reader_pkg::*;
  localparam int N = 4;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  apb_req_t    req     = '0;
  apb_rsp_t    rsp;
  logic [7:0]  sw;
  logic [3:0]  strobe;
  logic        flag;
  logic        err;
  logic        irq;
  logic [15:0] code;
  logic [15:0] b0      = 16'h0000;
  logic [15:0] b1      = 16'h0000;
  logic [31:0] rd;
  logic        pe;
  logic [3:0]  seen;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc       = 0;

  multiplexed_switch_reader #(.SCAN_CYCLES(N)) multiplexed_switch_reader_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .switch_input_base_i(sw), .strobe_output_base_o(strobe),
    .read_complete_flag_o(flag), .operation_error_flag_o(err),
    .error_code_word_o(code), .irq_o(irq));

  switch_bank_model switch_bank_model_inst (
    .clk_i(clk_i), .strobe_i(strobe), .bank0_bcd_i(b0), .bank1_bcd_i(b1), .code_o(sw));

  initial forever #2.5 clk_i = ~clk_i;

  task final_report;
  begin
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask : final_report

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
  begin
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  end
  endtask : chk

  // one apb transfer; waits for pready, only the bench timeout ends the wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
  begin
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end while (rsp.pready !== 1'b1);
    chk("pready wait", 32'd2, i);
    rd = rsp.prdata;
    pe = rsp.pslverr;
    req <= '0;
  end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
  begin
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  end
  endtask : rdc

  // strobes must step 1,2,4,8 from the idle state
  task strobe_seq;
    int i;
    logic [3:0] prev;
  begin
    for (int k = 0; k < 4; k++)
    begin
      prev = strobe;
      i = 0;
      do
      begin
        @(posedge clk_i);
        i++;
      end while (strobe === prev && i < 50);
      chk("strobe", 4'h1 << k, strobe);
    end
  end
  endtask : strobe_seq

  task wait_flag;
    int i;
    int n;
  begin
    i = 0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end while (flag !== 1'b1 && i < 100);
    while (flag === 1'b1 && n < 100)
    begin
      n++;
      @(posedge clk_i);
    end
    chk("flag width", N, n);
  end
  endtask : wait_flag

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc("ctrl", `OFF_CTRL, 32'h0000_0000);
    rdc("sel", `OFF_SEL, 32'h0000_0001);
    rdc("mask", `OFF_MASK, 32'h0000_0000);
    rdc("status", `OFF_STATUS, 32'h0000_0000);
    rdc("errcode", `OFF_ERRCODE, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("unmapped", 1'b1, pe);
    chk("strobe off", 4'h0, strobe);
    b0 <= 16'h5301;
    b1 <= 16'h0729;
    wr(`OFF_SEL, 32'h0000_0002);
    wr(`OFF_MASK, 32'h0000_0003);
    wr(`OFF_CTRL, 32'h0000_0001);
    strobe_seq();
    wait_flag();
    wr(`OFF_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk("strobe off", 4'h0, strobe);
    rdc("value0", `OFF_VALUE0, 32'd5301);
    rdc("value1", `OFF_VALUE1, 32'd729);
    rdc("status", `OFF_STATUS, 32'h0000_0001);
    chk("irq", 1'b1, irq);
    wr(`OFF_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 1'b0, irq);
    wr(`OFF_MASK, 32'h0000_0003);
    wr(`OFF_STATUS, 32'h0000_0001);
    rdc("status clr", `OFF_STATUS, 32'h0000_0000);
    chk("irq clr", 1'b0, irq);
    b0 <= 16'h9999;
    b1 <= 16'h1234;
    wr(`OFF_SEL, 32'h0000_0001);
    wr(`OFF_CTRL, 32'h0000_0001);
    strobe_seq();
    wait_flag();
    wr(`OFF_CTRL, 32'h0000_0000);
    rdc("value0", `OFF_VALUE0, 32'd9999);
    rdc("value1 kept", `OFF_VALUE1, 32'd729);
    // out-of-range selectors below and above the valid pair
    for (int s = 0; s < 4; s += 3)
    begin
      wr(`OFF_STATUS, 32'h0000_0003);
      wr(`OFF_SEL, s);
      wr(`OFF_CTRL, 32'h0000_0001);
      seen = 4'h0;
      repeat (6 * N)
      begin
        @(posedge clk_i);
        seen = seen | strobe;
      end
      chk("fault strobe", 4'h0, seen);
      chk("error flag", 1'b1, err);
      chk("error code", `ERR_RANGE, code);
      rdc("status", `OFF_STATUS, 32'h0000_0002);
      rdc("errcode", `OFF_ERRCODE, `ERR_RANGE);
      rdc("no read", `OFF_VALUE0, 32'd9999);
      chk("irq err", 1'b1, irq);
      wr(`OFF_CTRL, 32'h0000_0000);
    end
    wr(`OFF_WORK0, 32'hFFFF_FFFF);
    rdc("work0 idle", `OFF_WORK0, 32'h0001_0000);
    wr(`OFF_VALUE0, 32'h0000_1234);
    rdc("value0 ro", `OFF_VALUE0, 32'd9999);
    final_report();
  end
endmodule : multiplexed_switch_reader_tb

`default_nettype wire

// ### tb/switch_bank_model.sv
`timescale 1ns/100ps
`default_nettype none

module switch_bank_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  strobe_i,
  input  wire logic [15:0] bank0_bcd_i,
  input  wire logic [15:0] bank1_bcd_i,
  output var  logic [7:0]  code_o
);
  logic [7:0] last = 8'h00;

  // transistor-driven matrix: the selected digit of both banks appears at once
  always_comb
  begin
    case (strobe_i)
      4'h1:    code_o = {bank1_bcd_i[3:0], bank0_bcd_i[3:0]};
      4'h2:    code_o = {bank1_bcd_i[7:4], bank0_bcd_i[7:4]};
      4'h4:    code_o = {bank1_bcd_i[11:8], bank0_bcd_i[11:8]};
      4'h8:    code_o = {bank1_bcd_i[15:12], bank0_bcd_i[15:12]};
      // nothing selected: lines float, show a changing pattern
      default: code_o = ~last;
    endcase
  end

  always @(posedge clk_i) last <= code_o;
endmodule : switch_bank_model

`default_nettype wire
